// ==== rtl/sobr_pkg.sv ====
// Constants for the observation and burst register bank of the sensor.
// Assumes a single 50 MHz system clock and an 8-bit serial register port.
package sobr_pkg;

    // ------------------------------------------------------------------
    // Register addresses (7-bit serial address space).
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_OBSERVATION = 7'h3d;
    localparam logic [6:0] ADDR_INV_PART_ID = 7'h3f;
    localparam logic [6:0] ADDR_PIXEL_DUMP  = 7'h40;
    localparam logic [6:0] ADDR_MOTION_RPT  = 7'h50;
    localparam logic [6:0] ADDR_FW_DOWNLOAD = 7'h60;

    // ------------------------------------------------------------------
    // Observation register layout.
    // ------------------------------------------------------------------
    localparam int         OBS_FW_ACTIVE_BIT = 7;
    localparam int         OBS_PD_PULSE_BIT  = 5;
    localparam int         OBS_FRAME_B_BIT   = 1;
    localparam int         OBS_FRAME_A_BIT   = 0;
    localparam logic [7:0] OBS_IMPL_MASK     = 8'ha3;
    localparam logic [7:0] OBS_RESET         = 8'h00;
    localparam logic [7:0] PORT_RESET        = 8'h00;

    // ------------------------------------------------------------------
    // Burst lengths: one and two-thirds frames of pixels, seven motion
    // bytes.
    // ------------------------------------------------------------------
    localparam int          FRAME_PIXELS     = 900;
    localparam logic [10:0] PIXEL_BURST_LEN  = 11'((FRAME_PIXELS * 5) / 3);
    localparam logic [10:0] MOTION_BURST_LEN = 11'h007;
    localparam logic [10:0] IDX_MAX          = 11'h7ff;

    // ------------------------------------------------------------------
    // Serial framing and download buffer shape.
    // ------------------------------------------------------------------
    localparam logic [2:0] LAST_BIT   = 3'h7;
    localparam int         BYTE_W     = 8;
    localparam int         FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Serial port states.
    // ------------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_ADDR  = 4'h2,
        ST_RDATA = 4'h4,
        ST_WDATA = 4'h8
    } sobr_state_e;

endpackage

// ==== rtl/sobr_fifo.sv ====
// Small flip-flop FIFO used for the firmware download byte stream.
// Assumes both sides run on the system clock; all outputs registered.
`timescale 1ns/1ps
module sobr_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    nxt_wr_ptr;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW-1:0]    nxt_rd_ptr;
    logic [CW-1:0]    count_ff;
    logic [CW-1:0]    nxt_count;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------------
    // Next-state: head word and flags are precomputed so they leave flops.
    // ------------------------------------------------------------------
    always_comb
    begin
        push       = i_in_valid && o_in_ready;
        pop        = o_out_valid && i_out_ready;
        nxt_wr_ptr = push ? PW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
        nxt_rd_ptr = pop ? PW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
        nxt_count  = count_ff;
        if (push && !pop)
        begin
            nxt_count = count_ff + ONE;
        end
        else if (pop && !push)
        begin
            nxt_count = count_ff - ONE;
        end
    end

    // One storage entry per generate step; only the write slot changes.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_comb
            begin
                nxt_mem[g] = (push && wr_ptr_ff == PW'(g)) ? i_in_data
                                                           : mem_ff[g];
            end
            always_ff @(posedge i_clk_sys or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    mem_ff[g] <= '0;
                end
                else
                begin
                    mem_ff[g] <= nxt_mem[g];
                end
            end
        end
    endgenerate

    // Pointer, count and registered output stage.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            count_ff    <= '0;
            o_in_ready  <= 1'b1;
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end
        else
        begin
            wr_ptr_ff   <= nxt_wr_ptr;
            rd_ptr_ff   <= nxt_rd_ptr;
            count_ff    <= nxt_count;
            o_in_ready  <= (nxt_count != FULL);
            o_out_valid <= (nxt_count != '0);
            o_out_data  <= nxt_mem[nxt_rd_ptr];
        end
    end

endmodule

// ==== rtl/sobr_regs.sv ====
// Observation flags, inverted part identifier and burst ports of the
// sensor, reached through the four-wire serial port (SPI mode 3).
// Assumes the serial pins are asynchronous and are oversampled by the
// 50 MHz system clock; frame tick and firmware state come from on-chip
// logic on the same clock.
//
// What this block does
// - Observation bits set by processes, sticky until cleared.
// - Bit seven set while running downloaded firmware.
// - Bit five set on power-down pulse.
// - Bits one and zero set every frame.
// - Inverse address returns inverted part identifier.
// - Pixel burst streams one and two-thirds frames.
// - Motion burst streams seven report bytes in order.
// - Firmware bytes stream into download port.
`timescale 1ns/1ps
module sobr_regs
#(
    parameter logic [7:0] PART_IDENTIFIER = 8'h5a // Arbitrary value.
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic        i_ncs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_mosi,
    output logic             o_miso,
    output logic             o_miso_oe_n,
    input  wire logic        i_power_down_n,
    input  wire logic        i_frame_tick,
    input  wire logic        i_firmware_running,
    input  wire logic [7:0]  i_pixel_data,
    output logic             o_pixel_next,
    input  wire logic [7:0]  i_motion_status,
    input  wire logic [7:0]  i_delta_x,
    input  wire logic [7:0]  i_delta_y,
    input  wire logic [7:0]  i_surface_quality,
    input  wire logic [15:0] i_shutter,
    input  wire logic [7:0]  i_max_pixel,
    output logic [7:0]       o_fw_data,
    output logic             o_fw_valid,
    input  wire logic        i_fw_ready,
    output logic             o_load_ready,
    output logic [7:0]       o_observation
);
    import sobr_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers: bit 0 clock, 1 data in, 2 select, 3 power-down.
    // ------------------------------------------------------------------
    logic [3:0]  s1_ff;
    logic [3:0]  s2_ff;
    logic [3:0]  d_ff;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        pd_release;
    logic [7:0]  byte_in;
    logic [7:0]  sh_in_ff;
    logic [7:0]  obs_ff;

    // The first stage feeds only the second; edges come from stage two.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s1_ff <= 4'hd;
            s2_ff <= 4'hd;
            d_ff  <= 4'hd;
        end
        else
        begin
            s1_ff <= {i_power_down_n, i_ncs_n, i_mosi, i_sclk};
            s2_ff <= s1_ff;
            d_ff  <= s2_ff;
        end
    end

    assign sclk_rise  = s2_ff[0] && !d_ff[0];
    assign sclk_fall  = !s2_ff[0] && d_ff[0];
    assign pd_release = s2_ff[3] && !d_ff[3];
    assign byte_in    = {sh_in_ff[6:0], s2_ff[1]};

    // ------------------------------------------------------------------
    // Read data selection for single and burst registers.
    // ------------------------------------------------------------------
    function automatic logic [7:0] rd_byte(input logic [6:0]  a,
                                           input logic [10:0] idx);
        logic [7:0] r;
        r = PORT_RESET;
        case (a)
            ADDR_OBSERVATION: r = (idx == '0) ? obs_ff : PORT_RESET;
            ADDR_INV_PART_ID: r = (idx == '0) ? ~PART_IDENTIFIER
                                              : PORT_RESET;
            ADDR_PIXEL_DUMP:  r = (idx < PIXEL_BURST_LEN) ? i_pixel_data
                                                          : PORT_RESET;
            ADDR_MOTION_RPT:
            begin
                case (idx)
                    11'h000: r = i_motion_status;
                    11'h001: r = i_delta_x;
                    11'h002: r = i_delta_y;
                    11'h003: r = i_surface_quality;
                    11'h004: r = i_shutter[15:8];
                    11'h005: r = i_shutter[7:0];
                    11'h006: r = i_max_pixel;
                    default: r = PORT_RESET;
                endcase
            end
            default:          r = PORT_RESET;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Serial port engine.
    // ------------------------------------------------------------------
    sobr_state_e state_ff;
    sobr_state_e nxt_state;
    logic [2:0]  bit_cnt_ff;
    logic [2:0]  nxt_bit_cnt;
    logic [7:0]  nxt_sh_in;
    logic [7:0]  sh_out_ff;
    logic [7:0]  nxt_sh_out;
    logic [6:0]  addr_ff;
    logic [6:0]  nxt_addr;
    logic [10:0] idx_ff;
    logic [10:0] nxt_idx;
    logic        miso_ff;
    logic        nxt_miso;
    logic        oe_n_ff;
    logic        pix_next_ff;
    logic        nxt_pix_next;
    logic        push_ff;
    logic        nxt_push;
    logic        wr_obs_ff;
    logic        nxt_wr_obs;
    logic [7:0]  wdata_ff;
    logic [7:0]  nxt_wdata;
    logic        rd_load;
    logic [6:0]  rd_addr;
    logic [10:0] rd_idx;

    // Bytes complete on the eighth rising edge; read data shifts out on
    // falling edges so the master samples it stable on the next rise.
    // No wait is inserted after the address byte: the first bit is ready
    // before the first falling edge, at the cost of reading live inputs.
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_sh_in    = sh_in_ff;
        nxt_sh_out   = sh_out_ff;
        nxt_addr     = addr_ff;
        nxt_idx      = idx_ff;
        nxt_miso     = miso_ff;
        nxt_pix_next = 1'b0;
        nxt_push     = 1'b0;
        nxt_wr_obs   = 1'b0;
        nxt_wdata    = wdata_ff;
        rd_load      = 1'b0;
        rd_addr      = addr_ff;
        rd_idx       = idx_ff;
        if (s2_ff[2])
        begin
            nxt_state   = ST_IDLE;
            nxt_bit_cnt = '0;
        end
        else
        begin
            if (state_ff == ST_IDLE)
            begin
                nxt_state = ST_ADDR;
            end
            if (sclk_rise && state_ff != ST_IDLE)
            begin
                nxt_bit_cnt = bit_cnt_ff + 3'h1;
                nxt_sh_in   = byte_in;
                if (bit_cnt_ff == LAST_BIT)
                begin
                    case (state_ff)
                        ST_ADDR:
                        begin
                            nxt_addr = byte_in[6:0];
                            if (byte_in[7])
                            begin
                                nxt_state = ST_WDATA;
                            end
                            else
                            begin
                                nxt_state = ST_RDATA;
                                rd_load   = 1'b1;
                                rd_addr   = byte_in[6:0];
                                rd_idx    = '0;
                            end
                        end
                        ST_RDATA:
                        begin
                            rd_load = 1'b1;
                        end
                        ST_WDATA:
                        begin
                            nxt_wdata  = byte_in;
                            nxt_wr_obs = (addr_ff == ADDR_OBSERVATION);
                            nxt_push   = (addr_ff == ADDR_FW_DOWNLOAD);
                        end
                        default:
                        begin
                            nxt_state = ST_IDLE;
                        end
                    endcase
                end
            end
            if (rd_load)
            begin
                nxt_sh_out   = rd_byte(rd_addr, rd_idx);
                nxt_idx      = (rd_idx == IDX_MAX) ? rd_idx
                                                   : rd_idx + 11'h001;
                nxt_pix_next = (rd_addr == ADDR_PIXEL_DUMP)
                               && (rd_idx < PIXEL_BURST_LEN);
            end
            if (sclk_fall && state_ff == ST_RDATA)
            begin
                nxt_miso   = sh_out_ff[7];
                nxt_sh_out = {sh_out_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_ff    <= ST_IDLE;
            bit_cnt_ff  <= '0;
            sh_in_ff    <= PORT_RESET;
            sh_out_ff   <= PORT_RESET;
            addr_ff     <= '0;
            idx_ff      <= '0;
            miso_ff     <= 1'b0;
            oe_n_ff     <= 1'b1;
            pix_next_ff <= 1'b0;
            push_ff     <= 1'b0;
            wr_obs_ff   <= 1'b0;
            wdata_ff    <= PORT_RESET;
        end
        else
        begin
            state_ff    <= nxt_state;
            bit_cnt_ff  <= nxt_bit_cnt;
            sh_in_ff    <= nxt_sh_in;
            sh_out_ff   <= nxt_sh_out;
            addr_ff     <= nxt_addr;
            idx_ff      <= nxt_idx;
            miso_ff     <= nxt_miso;
            oe_n_ff     <= s2_ff[2];
            pix_next_ff <= nxt_pix_next;
            push_ff     <= nxt_push;
            wr_obs_ff   <= nxt_wr_obs;
            wdata_ff    <= nxt_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Observation flags: a hardware set always beats a software clear.
    // ------------------------------------------------------------------
    logic [7:0] nxt_obs;
    logic [7:0] obs_set;

    always_comb
    begin
        obs_set                    = 8'h00;
        obs_set[OBS_FW_ACTIVE_BIT] = i_firmware_running;
        obs_set[OBS_PD_PULSE_BIT]  = pd_release;
        obs_set[OBS_FRAME_B_BIT]   = i_frame_tick;
        obs_set[OBS_FRAME_A_BIT]   = i_frame_tick;
        nxt_obs = wr_obs_ff ? (wdata_ff & OBS_IMPL_MASK) : obs_ff;
        nxt_obs = (nxt_obs | obs_set) & OBS_IMPL_MASK;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            obs_ff <= OBS_RESET;
        end
        else
        begin
            obs_ff <= nxt_obs;
        end
    end

    // ------------------------------------------------------------------
    // Firmware download buffer; a byte offered while full is lost, so
    // the master must watch the load-ready output.
    // ------------------------------------------------------------------
    sobr_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fw_fifo
    (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_in_data   (wdata_ff),
        .i_in_valid  (push_ff),
        .o_in_ready  (o_load_ready),
        .o_out_data  (o_fw_data),
        .o_out_valid (o_fw_valid),
        .i_out_ready (i_fw_ready)
    );

    assign o_miso        = miso_ff;
    assign o_miso_oe_n   = oe_n_ff;
    assign o_pixel_next  = pix_next_ff;
    assign o_observation = obs_ff;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_motion_x_load;
        rd_load && rd_addr == ADDR_MOTION_RPT && rd_idx == 11'h001;
    endsequence

    sequence s_fw_byte_done;
        sclk_rise && !s2_ff[2] && state_ff == ST_WDATA
        && bit_cnt_ff == LAST_BIT && addr_ff == ADDR_FW_DOWNLOAD;
    endsequence

    obs_sticky_a: assert property (
        obs_ff[OBS_FRAME_A_BIT] && !wr_obs_ff |=> obs_ff[OBS_FRAME_A_BIT])
        else $error("Observation flag dropped without a write.");
    fw_flag_a: assert property (
        i_firmware_running |=> obs_ff[OBS_FW_ACTIVE_BIT])
        else $error("Firmware flag not set while firmware runs.");
    pd_pulse_a: assert property (
        $rose(s2_ff[3]) |=> obs_ff[OBS_PD_PULSE_BIT])
        else $error("Power-down pulse not flagged.");
    frame_set_a: assert property (
        i_frame_tick |=> obs_ff[OBS_FRAME_A_BIT] && obs_ff[OBS_FRAME_B_BIT])
        else $error("Frame flags not set on frame tick.");
    inv_id_a: assert property (
        rd_load && rd_addr == ADDR_INV_PART_ID && rd_idx == '0
        |=> sh_out_ff == ~PART_IDENTIFIER)
        else $error("Inverted identifier wrong.");
    pixel_next_a: assert property (
        rd_load && rd_addr == ADDR_PIXEL_DUMP
        |=> o_pixel_next == ($past(rd_idx) < PIXEL_BURST_LEN))
        else $error("Pixel advance pulse wrong.");
    motion_order_a: assert property (
        s_motion_x_load |=> sh_out_ff == $past(i_delta_x))
        else $error("Motion burst second byte is not X.");
    fw_push_a: assert property (
        s_fw_byte_done ##1 o_load_ready |=> o_fw_valid)
        else $error("Firmware byte not buffered.");
    reserved_zero_a: assert property (
        wr_obs_ff |=> (obs_ff & ~OBS_IMPL_MASK) == 8'h00)
        else $error("Reserved observation bits not zero.");

endmodule

// ==== tb/sobr_host_model.sv ====
// Serial port master that stands in for the microcontroller.
// Assumes it is driven from the falling edge of the system clock.
`timescale 1ns/1ps
module sobr_host_model
(
    input  wire logic i_clk_sys,
    input  wire logic i_miso,
    output logic      o_ncs_n,
    output logic      o_sclk,
    output logic      o_mosi
);
    logic [7:0] tx_buf [0:15];
    logic [7:0] rx_buf [0:15];

    // Mode 3: the clock idles high and rests between frames.
    initial
    begin
        o_ncs_n = 1'b1;
        o_sclk  = 1'b1;
        o_mosi  = 1'b1;
    end

    // Half a serial period is four system clocks, above the minimum.
    task automatic half();
        repeat (4) @(negedge i_clk_sys);
    endtask

    // Data changes after the falling edge; MISO is taken at the rise.
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_sclk = 1'b0;
            o_mosi = tx[i];
            half();
            o_sclk = 1'b1;
            rx[i]  = i_miso;
            half();
        end
    endtask

    // One frame: address byte, then n data bytes back to back.
    task automatic frame(input logic [7:0] addr, input int n);
        logic [7:0] junk;
        o_ncs_n = 1'b0;
        half();
        xbyte(addr, junk);
        for (int k = 0; k < n; k++)
            xbyte(tx_buf[k], rx_buf[k]);
        half();
        o_ncs_n = 1'b1;
        half();
        half();
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the observation and burst register bank.
// Assumes the host model above and the design files under rtl.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import sobr_pkg::*;
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic        pd_n    = 1'b1;
    logic        tick    = 1'b0;
    logic        fw_run  = 1'b0;
    logic        fw_rdy  = 1'b0;
    logic [7:0]  pix     = 8'h00;
    logic [7:0]  mot [0:6];
    logic        ncs_n, sclk, mosi, miso, oe_n, miso_w, pix_nxt;
    logic        miso_last = 1'b0;
    logic [7:0]  fw_data, obs;
    logic        fw_valid, load_rdy;
    int          err_total = 0;
    int          checks    = 0;

    // -------------------------------------------------------------
    // Clock, pins and instances.
    // -------------------------------------------------------------
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // A released MISO shows the inverse of its last bit, never a
    // value that could pass by luck.
    always @(posedge clk_sys)
        if (!oe_n) miso_last <= miso;
    assign miso_w = oe_n ? ~miso_last : miso;

    // Pixel source advances on each request.
    always @(posedge clk_sys)
        if (pix_nxt) pix <= pix + 8'h01;

    sobr_host_model host (.i_clk_sys(clk_sys), .i_miso(miso_w),
        .o_ncs_n(ncs_n), .o_sclk(sclk), .o_mosi(mosi));

    sobr_regs #(.PART_IDENTIFIER(8'h5a)) uut (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ncs_n(ncs_n),
        .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(oe_n),
        .i_power_down_n(pd_n), .i_frame_tick(tick),
        .i_firmware_running(fw_run), .i_pixel_data(pix),
        .o_pixel_next(pix_nxt), .i_motion_status(mot[0]),
        .i_delta_x(mot[1]), .i_delta_y(mot[2]),
        .i_surface_quality(mot[3]), .i_shutter({mot[4], mot[5]}),
        .i_max_pixel(mot[6]), .o_fw_data(fw_data), .o_fw_valid(fw_valid),
        .i_fw_ready(fw_rdy), .o_load_ready(load_rdy),
        .o_observation(obs));

    // -------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.tx_buf[0] = d;
        host.frame({1'b1, a}, 1);
    endtask

    task automatic rd(input logic [6:0] a, input int n);
        for (int k = 0; k < 16; k++) host.tx_buf[k] = 8'h00;
        host.frame({1'b0, a}, n);
    endtask

    task automatic t_reset();
        `CHK(obs, 8'h00)
        `CHK(oe_n, 1'b1)
        `CHK(load_rdy, 1'b1)
        `CHK(fw_valid, 1'b0)
    endtask

    task automatic t_inv_id();
        rd(ADDR_INV_PART_ID, 2);
        `CHK(host.rx_buf[0], 8'ha5)
        `CHK(host.rx_buf[1], 8'h00)
        rd(7'h3e, 1);
        `CHK(host.rx_buf[0], 8'h00)
    endtask

    // Clear, let one process act, read back; each process alone.
    task automatic t_obs();
        wr(ADDR_OBSERVATION, 8'h00);
        `CHK(obs, 8'h00)
        tick = 1'b1;
        @(negedge clk_sys) tick = 1'b0;
        repeat (30) @(negedge clk_sys);
        `CHK(obs, 8'h03)
        rd(ADDR_OBSERVATION, 1);
        `CHK(host.rx_buf[0], 8'h03)
        wr(ADDR_OBSERVATION, 8'hff);
        `CHK(obs, 8'ha3)
        wr(ADDR_OBSERVATION, 8'h00);
        pd_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        pd_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        `CHK(obs, 8'h20)
        wr(ADDR_OBSERVATION, 8'h00);
        fw_run = 1'b1;
        repeat (2) @(negedge clk_sys);
        fw_run = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK(obs, 8'h80)
        wr(ADDR_OBSERVATION, 8'h00);
        `CHK(obs, 8'h00)
    endtask

    task automatic t_motion();
        logic [7:0] exp [0:7];
        exp = '{8'h81, 8'h12, 8'hfe, 8'h40, 8'h12, 8'h34, 8'h3f, 8'h00};
        for (int k = 0; k < 7; k++) mot[k] = exp[k];
        rd(ADDR_MOTION_RPT, 8);
        for (int k = 0; k < 8; k++) `CHK(host.rx_buf[k], exp[k])
    endtask

    task automatic t_pixel();
        rd(ADDR_PIXEL_DUMP, 5);
        `CHK(host.rx_buf[0], 8'h00)
        for (int k = 1; k < 5; k++)
            `CHK(host.rx_buf[k], host.rx_buf[k-1] + 8'h01)
    endtask

    // Fill until refused with the consumer stalled, then drain.
    task automatic t_fw();
        for (int k = 0; k < 9; k++) host.tx_buf[k] = 8'(8'hc0 + k);
        host.frame({1'b1, ADDR_FW_DOWNLOAD}, 9);
        `CHK(load_rdy, 1'b0)
        for (int k = 0; k < 8; k++)
        begin
            `CHK(fw_valid, 1'b1)
            `CHK(fw_data, 8'(8'hc0 + k))
            fw_rdy = 1'b1;
            @(negedge clk_sys) fw_rdy = 1'b0;
            @(negedge clk_sys);
        end
        `CHK(fw_valid, 1'b0)
        `CHK(load_rdy, 1'b1)
    endtask

    // -------------------------------------------------------------
    // Run control.
    // -------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // The whole run is about 3000 clocks; nearly seven times that is a hang.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end

    initial
    begin
        for (int k = 0; k < 7; k++) mot[k] = 8'h00;
        repeat (16) @(negedge clk_sys);
        t_reset();
        arst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        t_inv_id();
        t_obs();
        t_motion();
        t_pixel();
        t_fw();
        stop_test();
    end
endmodule
